// ==== logic/lsc_pkg.sv ====
// Constants for the per-lane serdes control register pair and its management port
package lsc_pkg;

  // Register addresses on the management port
  localparam logic [4:0]  REG_CTRL_A   = 5'h07;
  localparam logic [4:0]  REG_CTRL_B   = 5'h08;

  // Reset values
  localparam logic [15:0] RST_CTRL_A   = 16'hdd05;
  localparam logic [15:0] RST_CTRL_B   = 16'h000d;
  localparam logic [7:0]  RST_B_LOW    = 8'h0d;

  // Field layout of lane_serdes_ctrl_a
  localparam int          SWING_LSB    = 12;
  localparam int          SWING_W      = 3;
  localparam int          LOS_BIT      = 11;
  localparam int          TXEN_BIT     = 10;
  localparam int          TXRATE_LSB   = 8;
  localparam int          RATE_W       = 2;
  localparam int          DE_LSB       = 4;
  localparam int          DE_W         = 4;
  localparam int          RXEN_BIT     = 2;
  localparam int          RXRATE_LSB   = 0;

  // Field layout of lane_serdes_ctrl_b
  localparam int          RXINV_BIT    = 15;
  localparam int          TXINV_BIT    = 14;
  localparam int          EQ_LSB       = 8;
  localparam int          EQ_W         = 4;
  localparam int          RSVD_B_LSB   = 0;
  localparam int          RSVD_B_W     = 8;

  // Lane rate codes; code 2'b11 is reserved but stored as written
  localparam logic [1:0]  RATE_FULL    = 2'h0;
  localparam logic [1:0]  RATE_HALF    = 2'h1;
  localparam logic [1:0]  RATE_QUARTER = 2'h2;

  // Management frame layout
  localparam logic [1:0]  OP_WRITE     = 2'h1;
  localparam logic [1:0]  OP_READ      = 2'h2;
  localparam logic [5:0]  PRE_LEN      = 6'h20;
  localparam logic [5:0]  HDR_LAST     = 6'h0c;
  localparam logic [5:0]  DATA_LAST    = 6'h0f;

  typedef enum logic [1:0] {
    MS_PRE  = 2'b00,
    MS_HDR  = 2'b01,
    MS_TA   = 2'b10,
    MS_DATA = 2'b11
  } lsc_mdio_state_type;

endpackage

// ==== logic/lsc_lane_serdes_regs.sv ====
// Per-lane serdes control register pair behind a management data serial slave
`timescale 1ns/1ps
`default_nettype none

module lsc_lane_serdes_regs #(
  parameter int         NUM_LANES = 8,
  parameter logic [4:0] PHY_ADDR  = 5'h00
) (
  input  wire logic                              clk_sys,
  input  wire logic                              reset_n,
  input  wire logic                              mdc,
  input  wire logic                              mdio_in,
  output var  logic                              mdio_out,
  output var  logic                              mdio_oe,
  input  wire logic                              transceiver_powerdown_n,
  input  wire logic                              global_powerdown,
  input  wire logic                              all_lane_write,
  input  wire logic [2:0]                        lane_select,
  output var  logic [NUM_LANES-1:0]              lane_signal_loss_detect_en,
  output var  logic [NUM_LANES-1:0]              tx_lane_enable,
  output var  logic [NUM_LANES-1:0]              rx_lane_enable,
  output var  logic [NUM_LANES*lsc_pkg::RATE_W-1:0]  tx_lane_rate,
  output var  logic [NUM_LANES*lsc_pkg::RATE_W-1:0]  rx_lane_rate,
  output var  logic [NUM_LANES*lsc_pkg::SWING_W-1:0] lane_output_swing,
  output var  logic [NUM_LANES*lsc_pkg::DE_W-1:0]    lane_deemphasis,
  output var  logic [NUM_LANES*lsc_pkg::EQ_W-1:0]    lane_equalizer,
  output var  logic [NUM_LANES-1:0]              rx_polarity_invert,
  output var  logic [NUM_LANES-1:0]              tx_polarity_invert
);
  import lsc_pkg::*;
  lsc_mdio_state_type   state_ff, nxt_state;
  logic [5:0]           cnt_ff, nxt_cnt;
  logic [11:0]          sr_ff, nxt_sr;
  logic [15:0]          dsr_ff, nxt_dsr;
  logic                 rd_ff, nxt_rd;
  logic [4:0]           reg_ff, nxt_reg;
  logic                 mdio_out_ff, nxt_out;
  logic                 mdio_oe_ff, nxt_oe;
  logic [12:0]          hdr;
  logic                 wr_en, mdc_rise, pwr_ok;
  logic [15:0]          wr_data;
  logic                 mdc_s1_ff, mdc_s2_ff, mdc_s3_ff;
  logic                 mdio_s1_ff, mdio_s2_ff;
  logic                 pd_s1_ff, pd_s2_ff;
  logic [15:0]          ctrl_a_ff [NUM_LANES], nxt_ctrl_a [NUM_LANES];
  logic [15:0]          ctrl_b_ff [NUM_LANES], nxt_ctrl_b [NUM_LANES];
  logic [NUM_LANES-1:0] tx_en_ff, nxt_tx_en;
  logic [NUM_LANES-1:0] rx_en_ff, nxt_rx_en;

  function automatic logic lane_hit(input logic [2:0] lane, input logic all, input logic [2:0] sel);
    lane_hit = all || (lane == sel);
  endfunction
  function automatic logic [15:0] read_value(input logic [4:0] addr, input logic [2:0] sel);
    read_value = 16'h0000;
    if (addr == REG_CTRL_A)
      read_value = ctrl_a_ff[sel];
    else if (addr == REG_CTRL_B)
      read_value = ctrl_b_ff[sel];
  endfunction

  // Pin inputs cross two flops; the third mdc flop only serves edge detection
  always_ff @(posedge clk_sys)
  begin
    mdc_s1_ff  <= mdc;
    mdc_s2_ff  <= mdc_s1_ff;
    mdc_s3_ff  <= mdc_s2_ff;
    mdio_s1_ff <= mdio_in;
    mdio_s2_ff <= mdio_s1_ff;
    pd_s1_ff   <= transceiver_powerdown_n;
    pd_s2_ff   <= pd_s1_ff;
  end
  assign mdc_rise = mdc_s2_ff && !mdc_s3_ff;
  assign pwr_ok   = pd_s2_ff && !global_powerdown;

  // Frame engine: all sampling and driving happens after a synchronised mdc rise,
  // so mdc must stay well below a quarter of clk_sys
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_sr    = sr_ff;
    nxt_dsr   = dsr_ff;
    nxt_rd    = rd_ff;
    nxt_reg   = reg_ff;
    nxt_out   = mdio_out_ff;
    nxt_oe    = mdio_oe_ff;
    wr_en     = 1'b0;
    wr_data   = 16'h0000;
    hdr       = {sr_ff, mdio_s2_ff};
    if (mdc_rise)
    begin
      unique case (state_ff)
        MS_PRE:
        begin
          if (mdio_s2_ff)
          begin
            if (cnt_ff != PRE_LEN)
              nxt_cnt = cnt_ff + 6'h01;
          end
          else
          begin
            if (cnt_ff == PRE_LEN)
              nxt_state = MS_HDR;
            nxt_cnt = 6'h00;
          end
        end
        MS_HDR:
        begin
          nxt_sr  = hdr[11:0];
          nxt_cnt = cnt_ff + 6'h01;
          if (cnt_ff == HDR_LAST)
          begin
            nxt_cnt = 6'h00;
            nxt_reg = hdr[4:0];
            nxt_rd  = (hdr[11:10] == OP_READ);
            // Read data is captured here, so a later lane_select change
            // does not tear the word being shifted out
            nxt_dsr = read_value(hdr[4:0], lane_select);
            if (hdr[12] && hdr[9:5] == PHY_ADDR &&
                (hdr[11:10] == OP_READ || hdr[11:10] == OP_WRITE))
              nxt_state = MS_TA;
            else
              nxt_state = MS_PRE;
          end
        end
        MS_TA:
        begin
          nxt_cnt = cnt_ff + 6'h01;
          if (cnt_ff == 6'h00)
          begin
            nxt_oe  = rd_ff;
            nxt_out = 1'b0;
          end
          else
          begin
            nxt_cnt   = 6'h00;
            nxt_state = MS_DATA;
            if (rd_ff)
            begin
              nxt_out = dsr_ff[15];
              nxt_dsr = {dsr_ff[14:0], 1'b0};
            end
          end
        end
        MS_DATA:
        begin
          nxt_cnt = cnt_ff + 6'h01;
          if (rd_ff)
          begin
            nxt_out = dsr_ff[15];
            nxt_dsr = {dsr_ff[14:0], 1'b0};
          end
          else
            nxt_dsr = {dsr_ff[14:0], mdio_s2_ff};
          if (cnt_ff == DATA_LAST)
          begin
            nxt_state = MS_PRE;
            nxt_cnt   = 6'h00;
            nxt_oe    = 1'b0;
            nxt_out   = 1'b0;
            wr_en     = !rd_ff;
            wr_data   = {dsr_ff[14:0], mdio_s2_ff};
          end
        end
      endcase
    end
  end
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      state_ff    <= MS_PRE;
      cnt_ff      <= 6'h00;
      sr_ff       <= 12'h000;
      dsr_ff      <= 16'h0000;
      rd_ff       <= 1'b0;
      reg_ff      <= 5'h00;
      mdio_out_ff <= 1'b0;
      mdio_oe_ff  <= 1'b0;
    end
    else
    begin
      state_ff    <= nxt_state;
      cnt_ff      <= nxt_cnt;
      sr_ff       <= nxt_sr;
      dsr_ff      <= nxt_dsr;
      rd_ff       <= nxt_rd;
      reg_ff      <= nxt_reg;
      mdio_out_ff <= nxt_out;
      mdio_oe_ff  <= nxt_oe;
    end
  end

  // Register bank; all fields stay plain read/write, reserved codes included
  always_comb
  begin
    for (int i = 0; i < NUM_LANES; i++)
    begin
      nxt_ctrl_a[i] = ctrl_a_ff[i];
      nxt_ctrl_b[i] = ctrl_b_ff[i];
      if (wr_en && lane_hit(3'(i), all_lane_write, lane_select))
      begin
        if (reg_ff == REG_CTRL_A)
          nxt_ctrl_a[i] = wr_data;
        else if (reg_ff == REG_CTRL_B)
          nxt_ctrl_b[i] = wr_data;
      end
      nxt_tx_en[i] = ctrl_a_ff[i][TXEN_BIT] && pwr_ok;
      nxt_rx_en[i] = ctrl_a_ff[i][RXEN_BIT] && pwr_ok;
    end
  end
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < NUM_LANES; i++)
      begin
        ctrl_a_ff[i] <= RST_CTRL_A;
        ctrl_b_ff[i] <= RST_CTRL_B;
      end
      tx_en_ff <= '0;
      rx_en_ff <= '0;
    end
    else
    begin
      ctrl_a_ff <= nxt_ctrl_a;
      ctrl_b_ff <= nxt_ctrl_b;
      tx_en_ff  <= nxt_tx_en;
      rx_en_ff  <= nxt_rx_en;
    end
  end
  assign mdio_out       = mdio_out_ff;
  assign mdio_oe        = mdio_oe_ff;
  assign tx_lane_enable = tx_en_ff;
  assign rx_lane_enable = rx_en_ff;

  for (genvar g = 0; g < NUM_LANES; g++)
  begin : g_lane
    assign lane_signal_loss_detect_en[g]     = ctrl_a_ff[g][LOS_BIT];
    assign tx_lane_rate[g*RATE_W +: RATE_W]  = ctrl_a_ff[g][TXRATE_LSB +: RATE_W];
    assign rx_lane_rate[g*RATE_W +: RATE_W]  = ctrl_a_ff[g][RXRATE_LSB +: RATE_W];
    assign lane_output_swing[g*SWING_W +: SWING_W] = ctrl_a_ff[g][SWING_LSB +: SWING_W];
    assign lane_deemphasis[g*DE_W +: DE_W]   = ctrl_a_ff[g][DE_LSB +: DE_W];
    assign rx_polarity_invert[g]             = ctrl_b_ff[g][RXINV_BIT];
    assign tx_polarity_invert[g]             = ctrl_b_ff[g][TXINV_BIT];
    assign lane_equalizer[g*EQ_W +: EQ_W]    = ctrl_b_ff[g][EQ_LSB +: EQ_W];
  end
  tx_power_off_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (!pd_s2_ff || global_powerdown) |=> tx_lane_enable == '0)
    else $error("tx lane enabled while powered down");
  rx_power_off_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (!pd_s2_ff || global_powerdown) |=> rx_lane_enable == '0)
    else $error("rx lane enabled while powered down");
  tx_enable_follow_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    pwr_ok && ctrl_a_ff[0][TXEN_BIT] |=> tx_lane_enable[0])
    else $error("tx lane enable not following register");
  los_reset_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $past(!reset_n) |-> lane_signal_loss_detect_en == '1)
    else $error("loss detect enable wrong after reset");
  rate_reset_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $past(!reset_n) |-> tx_lane_rate[RATE_W-1:0] == RATE_HALF && rx_lane_rate[RATE_W-1:0] == RATE_HALF)
    else $error("lane rate wrong after reset");
  swing_reset_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $past(!reset_n) |-> lane_output_swing[SWING_W-1:0] == 3'h5 && lane_deemphasis[DE_W-1:0] == 4'h0)
    else $error("swing or de-emphasis wrong after reset");
  ctrl_b_reset_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $past(!reset_n) |-> ctrl_b_ff[NUM_LANES-1][RSVD_B_LSB +: RSVD_B_W] == RST_B_LOW
      && lane_equalizer[EQ_W-1:0] == 4'h0 && rx_polarity_invert == '0 && tx_polarity_invert == '0)
    else $error("second control register wrong after reset");
  global_write_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    wr_en && all_lane_write && reg_ff == REG_CTRL_B
      |=> ctrl_b_ff[NUM_LANES-1] == $past(wr_data) && ctrl_b_ff[0] == $past(wr_data))
    else $error("global write missed a lane");
  single_write_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    wr_en && !all_lane_write && reg_ff == REG_CTRL_A
      |=> ctrl_a_ff[$past(lane_select)] == $past(wr_data)
        && ctrl_a_ff[3'($past(lane_select) + 3'h1)] == $past(ctrl_a_ff[3'(lane_select + 3'h1)]))
    else $error("lane write hit the wrong lane");
  drive_window_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    mdio_oe |-> rd_ff && (state_ff == MS_TA || state_ff == MS_DATA))
    else $error("mdio driven outside a read turnaround or data phase");
endmodule

`default_nettype wire

// ==== testbench/testbench.sv ====
// Self-checking bench for the lane serdes control registers over management frames
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import lsc_pkg::*;

  logic        clk_sys = 1'b0;
  logic        reset_n = 1'b0;
  logic        mdc = 1'b0;
  logic        tb_d = 1'b1;
  logic        tb_oe = 1'b0;
  logic        pd_n = 1'b1;
  logic        gpd = 1'b0;
  logic        alw = 1'b1;
  logic [2:0]  lsel = 3'h0;
  logic        mdio_out;
  logic        mdio_oe;
  logic        mdio_wire;
  logic        bit_q;
  logic [7:0]  los_en, tx_en, rx_en, rx_inv, tx_inv;
  logic [15:0] tx_rate, rx_rate;
  logic [23:0] swing;
  logic [31:0] deemph, eq;
  int          bad_count = 0;
  int          n_tests = 0;

  // Line has a pull-up, so a released bus reads 1
  assign mdio_wire = mdio_oe ? mdio_out : (tb_oe ? tb_d : 1'b1);

  always #5 clk_sys = ~clk_sys;

  lsc_lane_serdes_regs dut_u (
    .clk_sys(clk_sys), .reset_n(reset_n), .mdc(mdc), .mdio_in(mdio_wire),
    .mdio_out(mdio_out), .mdio_oe(mdio_oe), .transceiver_powerdown_n(pd_n),
    .global_powerdown(gpd), .all_lane_write(alw), .lane_select(lsel),
    .lane_signal_loss_detect_en(los_en), .tx_lane_enable(tx_en), .rx_lane_enable(rx_en),
    .tx_lane_rate(tx_rate), .rx_lane_rate(rx_rate), .lane_output_swing(swing),
    .lane_deemphasis(deemph), .lane_equalizer(eq), .rx_polarity_invert(rx_inv),
    .tx_polarity_invert(tx_inv)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // One mdc period at 2.5 MHz; mdio is taken just before the rise, since the
  // slave moves to its next bit a few clocks after each rise
  task automatic send(input logic d, input logic en);
    @(negedge clk_sys);
    mdc <= 1'b0;
    tb_d <= d;
    tb_oe <= en;
    repeat (20) @(negedge clk_sys);
    bit_q = mdio_wire;
    mdc <= 1'b1;
    repeat (20) @(negedge clk_sys);
  endtask

  task automatic frame(input logic [4:0] phy, input logic rd, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] q);
    logic [13:0] hdr;
    hdr = {2'b01, (rd ? OP_READ : OP_WRITE), phy, ra};
    for (int i = 0; i < 32; i++) send(1'b1, 1'b1);
    for (int i = 13; i >= 0; i--) send(hdr[i], 1'b1);
    send(1'b1, !rd);
    send(1'b0, !rd);
    for (int i = 15; i >= 0; i--)
    begin
      send(wd[i], !rd);
      q[i] = bit_q;
    end
    @(negedge clk_sys);
    mdc <= 1'b0;
    tb_oe <= 1'b0;
    repeat (10) @(negedge clk_sys);
  endtask

  task automatic wr(input logic [4:0] ra, input logic [15:0] wd);
    logic [15:0] q;
    frame(5'h00, 1'b0, ra, wd, q);
  endtask

  task automatic rd_chk(input logic [4:0] ra, input logic [15:0] exp, input string m);
    logic [15:0] q;
    frame(5'h00, 1'b1, ra, 16'h0000, q);
    chk(32'(q), 32'(exp), m);
  endtask

  task automatic test_reset;
    chk(32'(los_en), 32'hff, "loss detect default");
    chk(32'(tx_en), 32'hff, "tx enable default");
    chk(32'(rx_en), 32'hff, "rx enable default");
    chk(32'(tx_rate), 32'h5555, "tx rate default");
    chk(32'(rx_rate), 32'h5555, "rx rate default");
    chk(32'(swing), 32'({8{3'b101}}), "swing default");
    chk(deemph, 32'h0, "deemphasis default");
    chk(32'({rx_inv, tx_inv}), 32'h0, "polarity default");
    chk(eq, 32'h0, "equalizer default");
    rd_chk(REG_CTRL_A, RST_CTRL_A, "ctrl_a reset");
    rd_chk(REG_CTRL_B, RST_CTRL_B, "ctrl_b reset");
    $display("test reset done");
  endtask

  task automatic test_global;
    alw = 1'b1;
    wr(REG_CTRL_A, 16'h33fa);
    chk(32'({los_en, tx_en, rx_en}), 32'h0, "enables cleared");
    chk(32'({tx_rate, rx_rate}), 32'hffffaaaa, "rates incl reserved");
    chk(32'(swing), 32'({8{3'b011}}), "swing all lanes");
    chk(deemph, 32'hffffffff, "deemphasis max");
    wr(REG_CTRL_B, 16'h8a5c);
    chk(32'({rx_inv, tx_inv}), 32'hff00, "polarity all lanes");
    chk(eq, 32'haaaaaaaa, "equalizer all lanes");
    lsel = 3'h5;
    rd_chk(REG_CTRL_A, 16'h33fa, "ctrl_a lane 5");
    rd_chk(REG_CTRL_B, 16'h8a5c, "ctrl_b reserved byte rw");
    $display("test global done");
  endtask

  task automatic test_lane;
    alw = 1'b0;
    lsel = 3'h3;
    wr(REG_CTRL_A, 16'h7f05);
    wr(REG_CTRL_B, 16'h400d);
    chk(32'(swing), 32'({{4{3'b011}}, 3'b111, {3{3'b011}}}), "swing lane 3");
    chk(32'(rx_rate), 32'haa6a, "rx rate lane 3");
    chk(32'({los_en, tx_en, rx_en}), 32'h080808, "enables lane 3");
    chk(32'({rx_inv, tx_inv}), 32'hf708, "polarity lane 3");
    rd_chk(REG_CTRL_A, 16'h7f05, "ctrl_a lane 3");
    lsel = 3'h2;
    rd_chk(REG_CTRL_A, 16'h33fa, "ctrl_a lane 2 kept");
    $display("test lane done");
  endtask

  task automatic test_powerdown;
    @(negedge clk_sys);
    gpd = 1'b1;
    repeat (2) @(negedge clk_sys);
    chk(32'({tx_en, rx_en}), 32'h0, "control bit forces off");
    gpd = 1'b0;
    repeat (3) @(negedge clk_sys);
    chk(32'({tx_en, rx_en}), 32'h0808, "enables return");
    pd_n = 1'b0;
    repeat (4) @(negedge clk_sys);
    chk(32'({tx_en, rx_en}), 32'h0, "pin forces off");
    pd_n = 1'b1;
    repeat (5) @(negedge clk_sys);
    chk(32'({tx_en, rx_en}), 32'h0808, "enables after pin");
    $display("test powerdown done");
  endtask

  task automatic test_refused;
    logic [15:0] q;
    lsel = 3'h3;
    rd_chk(5'h09, 16'h0000, "unmapped read");
    wr(5'h09, 16'hffff);
    frame(5'h01, 1'b0, REG_CTRL_A, 16'h0000, q);
    rd_chk(REG_CTRL_A, 16'h7f05, "foreign frames ignored");
    $display("test refused done");
  endtask

  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    repeat (5) @(negedge clk_sys);
    reset_n = 1'b1;
    repeat (8) @(negedge clk_sys);
    test_reset();
    test_global();
    test_lane();
    test_powerdown();
    test_refused();
    results();
  end

  // Fourteen frames of about 2600 cycles each fit well inside this span
  initial
  begin
    repeat (90000) @(posedge clk_sys);
    bad_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    results();
  end
endmodule

`default_nettype wire
